// >>> include/tsc_pkg.sv
`default_nettype none

package tsc_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int         CMD_BITS      = 8;
	localparam int         RES_BITS      = 12;
	localparam logic [3:0] LAST_CMD_BIT  = 4'h7;
	localparam logic [3:0] LAST_RES_BIT  = 4'hb;
	localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
	localparam logic [3:0] BIT_CNT_ONE   = 4'h1;
	localparam logic [11:0] SAR_MSB_MASK = 12'h800;

	// ------------------------------------------------------------
	// Command field layout and codes
	// ------------------------------------------------------------
	localparam int         SRC_LSB       = 4;
	localparam int         SRC_W         = 3;
	localparam int         PD_HI_POS     = 1;
	localparam int         PD_LO_POS     = 0;
	localparam logic [2:0] SRC_CODE_X    = 3'h5;
	localparam logic [2:0] SRC_CODE_Y    = 3'h1;
	localparam logic [2:0] SRC_CODE_Z1   = 3'h3;
	localparam logic [2:0] SRC_CODE_Z2   = 3'h4;
	localparam logic [2:0] SRC_CODE_TEMP = 3'h0;
	localparam logic [2:0] SRC_CODE_BAT  = 3'h2;
	localparam logic [2:0] SRC_CODE_AUXA = 3'h6;
	localparam logic [2:0] SRC_CODE_AUXB = 3'h7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic        RST_PEN_EN     = 1'b1;
	localparam logic        RST_POWER_DOWN = 1'b1;
	localparam logic [11:0] RST_RESULT     = 12'h000;
	localparam logic [7:0]  RST_CMD        = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TSC_MEAS_X, TSC_MEAS_Y, TSC_MEAS_Z1, TSC_MEAS_Z2,
		TSC_MEAS_TEMP, TSC_MEAS_BATTERY, TSC_MEAS_AUX_A, TSC_MEAS_AUX_B
	} tsc_meas_t;

	typedef enum logic [2:0] {
		TSC_ADC_NONE, TSC_ADC_X_PLUS, TSC_ADC_Y_PLUS, TSC_ADC_Y_MINUS,
		TSC_ADC_TEMP, TSC_ADC_BATTERY, TSC_ADC_AUX_A, TSC_ADC_AUX_B
	} tsc_adc_sel_t;

	typedef struct packed {
		logic         x_plus_drive;
		logic         x_minus_drive;
		logic         y_plus_drive;
		logic         y_minus_drive;
		logic         x_plus_pullup;
		tsc_adc_sel_t adc_sel;
	} tsc_plate_ctl_t;

	typedef struct packed {
		tsc_meas_t meas;
		logic      pen_en;
		logic      power_down;
	} tsc_cmd_t;

endpackage

`default_nettype wire

// >>> rtl/tsc_plate_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tsc_plate_ctrl
	import tsc_pkg::*;
(
	input  wire logic           i_measuring,
	input  wire logic           i_pen_wait,
	input  wire tsc_meas_t      i_meas,
	output tsc_plate_ctl_t      o_plate
);

	// ------------------------------------------------------------
	// Plate switch matrix
	// ------------------------------------------------------------
	always_comb begin
		o_plate = '0;
		o_plate.adc_sel = TSC_ADC_NONE;
		if (i_measuring) begin
			unique case (i_meas)
				TSC_MEAS_X: begin
					o_plate.x_plus_drive  = 1'b1; // [RULE_12]
					o_plate.x_minus_drive = 1'b1; // [RULE_12]
					o_plate.adc_sel       = TSC_ADC_Y_PLUS; // [RULE_12]
				end
				TSC_MEAS_Y: begin
					o_plate.y_plus_drive  = 1'b1; // [RULE_13]
					o_plate.y_minus_drive = 1'b1; // [RULE_13]
					o_plate.adc_sel       = TSC_ADC_X_PLUS; // [RULE_13]
				end
				TSC_MEAS_Z1: begin
					o_plate.y_plus_drive  = 1'b1; // [RULE_14]
					o_plate.x_minus_drive = 1'b1; // [RULE_14]
					o_plate.adc_sel       = TSC_ADC_X_PLUS; // [RULE_14]
				end
				TSC_MEAS_Z2: begin
					o_plate.y_plus_drive  = 1'b1; // [RULE_14]
					o_plate.x_minus_drive = 1'b1; // [RULE_14]
					o_plate.adc_sel       = TSC_ADC_Y_MINUS; // [RULE_14]
				end
				// Plates stay open for internal sources
				TSC_MEAS_TEMP:    o_plate.adc_sel = TSC_ADC_TEMP; // [RULE_15]
				TSC_MEAS_BATTERY: o_plate.adc_sel = TSC_ADC_BATTERY; // [RULE_15]
				TSC_MEAS_AUX_A:   o_plate.adc_sel = TSC_ADC_AUX_A; // [RULE_15]
				TSC_MEAS_AUX_B:   o_plate.adc_sel = TSC_ADC_AUX_B; // [RULE_15]
			endcase
		end else if (i_pen_wait) begin
			o_plate.x_plus_pullup = 1'b1; // [RULE_16]
			o_plate.y_minus_drive = 1'b1; // [RULE_16]
		end
	end

endmodule

`default_nettype wire

// >>> rtl/tsc_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

//Function
//[RULE_01] Result bits leave on serial clock falls
//[RULE_02] MSB appears as busy falls
//[RULE_03] Result output low when not shifting
//[RULE_04] Chip select high floats result, busy
//[RULE_05] Busy low once chip select low
//[RULE_06] Busy high from eighth to ninth fall
//[RULE_07] Eight command bits sampled on rises
//[RULE_08] Host keeps command input low idle
//[RULE_09] Commands accepted only with chip select low
//[RULE_10] Enabled pen interrupt pulls low on touch (code: only while chip select high)
//[RULE_11] Disabled pen interrupt stays released high
//[RULE_12] X: drive X plates, sense Y plus
//[RULE_13] Y: drive Y plates, sense X plus
//[RULE_14] Pressure: drive Y plus, X minus
//[RULE_15] Internal sources leave all plates open
//[RULE_16] Pen wait: X plus pullup, Y minus ground
//[RULE_17] Successive approximation gives twelve-bit results
//[RULE_18] Both power-down bits zero: full power-down
//[RULE_19] Remaining bits descend, then output low
//[RULE_20] Command fields decoded by named encoding
module tsc_serial_ctrl
	import tsc_pkg::*;
(
	input  wire logic           i_clk,
	input  wire logic           i_sys_rst,
	input  wire logic           i_chip_select_n,
	input  wire logic           i_serial_clock,
	input  wire logic           i_cmd_in,
	input  wire logic           i_pen_touched,
	input  wire logic           i_sar_cmp_high,
	output logic                o_result_out,
	output logic                o_result_out_oe,
	output logic                o_busy,
	output logic                o_busy_oe,
	output logic                o_touch_irq_n,
	output logic                o_touch_irq_n_oe,
	output logic [11:0]         o_sar_dac_code,
	output logic                o_sar_sample,
	output logic [11:0]         o_result_word,
	output logic                o_result_valid,
	output logic                o_power_down,
	output logic                o_pen_irq_en,
	output tsc_plate_ctl_t      o_plate
);

	// ------------------------------------------------------------
	// Frame states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_COMMAND, ST_ACQUIRE, ST_CONVERT, ST_DONE
	} tsc_state_t;

	tsc_state_t   state_reg;
	tsc_state_t   state_next;
	logic         sclk_reg;
	logic         sclk_rise;
	logic         sclk_fall;
	logic [3:0]   bit_cnt_reg;
	logic [7:0]   shift_reg;
	logic [7:0]   cmd_word;
	tsc_cmd_t     cmd_reg;
	tsc_cmd_t     cmd_dec;
	logic [11:0]  code_reg;
	logic [11:0]  mask_reg;
	logic [11:0]  code_next;
	logic         out_reg;
	logic         busy_reg;
	logic         irq_drive_reg;
	logic         valid_reg;
	logic [11:0]  word_reg;
	logic         measuring;
	logic         pen_wait;

	// ------------------------------------------------------------
	// Serial clock edges
	// ------------------------------------------------------------
	// Serial clock is synchronous to i_clk, so a single history
	// flop is enough; it must stay below half the system rate.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sclk_reg <= 1'b0;
		end else begin
			sclk_reg <= i_serial_clock;
		end
	end

	assign sclk_rise = i_serial_clock & ~sclk_reg;
	assign sclk_fall = ~i_serial_clock & sclk_reg;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	assign cmd_word = {shift_reg[6:0], i_cmd_in};

	always_comb begin
		cmd_dec.power_down = ~cmd_word[PD_HI_POS] & ~cmd_word[PD_LO_POS]; // [RULE_18]
		cmd_dec.pen_en     = ~cmd_word[PD_LO_POS];
		unique case (cmd_word[SRC_LSB +: SRC_W]) // [RULE_20]
			SRC_CODE_X:    cmd_dec.meas = TSC_MEAS_X;
			SRC_CODE_Y:    cmd_dec.meas = TSC_MEAS_Y;
			SRC_CODE_Z1:   cmd_dec.meas = TSC_MEAS_Z1;
			SRC_CODE_Z2:   cmd_dec.meas = TSC_MEAS_Z2;
			SRC_CODE_TEMP: cmd_dec.meas = TSC_MEAS_TEMP;
			SRC_CODE_BAT:  cmd_dec.meas = TSC_MEAS_BATTERY;
			SRC_CODE_AUXA: cmd_dec.meas = TSC_MEAS_AUX_A;
			SRC_CODE_AUXB: cmd_dec.meas = TSC_MEAS_AUX_B;
		endcase
	end

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				state_next = ST_COMMAND;
			end
			ST_COMMAND: begin
				if (sclk_rise && bit_cnt_reg == LAST_CMD_BIT) begin
					state_next = ST_ACQUIRE; // [RULE_07]
				end
			end
			ST_ACQUIRE: begin
				if (sclk_fall) begin
					state_next = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (sclk_fall && bit_cnt_reg == LAST_RES_BIT) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_DONE;
			end
		endcase
		// Chip select high aborts any frame in progress
		if (i_chip_select_n) begin
			state_next = ST_IDLE; // [RULE_09]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Bit counter
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_chip_select_n) begin
			bit_cnt_reg <= BIT_CNT_ZERO;
		end else if (state_reg == ST_COMMAND && sclk_rise) begin
			if (bit_cnt_reg == LAST_CMD_BIT) begin
				bit_cnt_reg <= BIT_CNT_ZERO;
			end else begin
				bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
			end
		end else if (state_reg == ST_CONVERT && sclk_fall) begin
			bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// Command shifter and latch
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_chip_select_n) begin
			shift_reg <= RST_CMD;
		end else if (state_reg == ST_COMMAND && sclk_rise) begin
			shift_reg <= cmd_word; // [RULE_07]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cmd_reg.meas       <= TSC_MEAS_TEMP;
			cmd_reg.pen_en     <= RST_PEN_EN;
			cmd_reg.power_down <= RST_POWER_DOWN;
		end else if (!i_chip_select_n && state_reg == ST_COMMAND && sclk_rise
			&& bit_cnt_reg == LAST_CMD_BIT) begin
			cmd_reg <= cmd_dec; // [RULE_09]
		end
	end

	// ------------------------------------------------------------
	// Successive approximation
	// ------------------------------------------------------------
	// Each fall keeps or drops the trial bit from the comparator,
	// then arms the next lower bit.
	always_comb begin
		code_next = i_sar_cmp_high ? code_reg : (code_reg & ~mask_reg);
		code_next = code_next | (mask_reg >> 1);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			code_reg <= RST_RESULT;
			mask_reg <= RST_RESULT;
		end else if (state_reg == ST_ACQUIRE && sclk_fall) begin
			code_reg <= SAR_MSB_MASK; // [RULE_17]
			mask_reg <= SAR_MSB_MASK;
		end else if (state_reg == ST_CONVERT && sclk_fall) begin
			code_reg <= code_next; // [RULE_17]
			mask_reg <= mask_reg >> 1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			word_reg  <= RST_RESULT;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			if (state_reg == ST_CONVERT && sclk_fall && bit_cnt_reg == LAST_RES_BIT) begin
				word_reg  <= code_next & ~(mask_reg >> 1);
				valid_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Result output
	// ------------------------------------------------------------
	// Comparator decision goes straight out, MSB first.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_chip_select_n) begin
			out_reg <= 1'b0;
		end else if (state_reg == ST_CONVERT && sclk_fall) begin
			out_reg <= i_sar_cmp_high; // [RULE_01] [RULE_02] [RULE_19]
		end else if (state_reg == ST_DONE && sclk_fall) begin
			out_reg <= 1'b0; // [RULE_19]
		end else if (state_reg != ST_CONVERT && state_reg != ST_DONE) begin
			out_reg <= 1'b0; // [RULE_03]
		end
	end

	// ------------------------------------------------------------
	// Busy output
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_chip_select_n) begin
			busy_reg <= 1'b0; // [RULE_05]
		end else if (state_reg == ST_ACQUIRE && sclk_fall) begin
			busy_reg <= 1'b1; // [RULE_06]
		end else if (sclk_fall) begin
			busy_reg <= 1'b0; // [RULE_06]
		end
	end

	// ------------------------------------------------------------
	// Pen interrupt
	// ------------------------------------------------------------
	// Open drain: low while touched with pen_en set and chip select high, released otherwise.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			irq_drive_reg <= 1'b0;
		end else begin
			irq_drive_reg <= i_chip_select_n && cmd_reg.pen_en && i_pen_touched; // [RULE_10] [RULE_11]
		end
	end

	// ------------------------------------------------------------
	// Plate control
	// ------------------------------------------------------------
	// Tracking starts once the command is in; plates go to the pen
	// wait setup (all open if pen_en is clear) as soon as the last result bit is decided.
	assign measuring = (state_reg == ST_ACQUIRE) || (state_reg == ST_CONVERT);
	assign pen_wait  = cmd_reg.pen_en && !measuring; // [RULE_16]

	tsc_plate_ctrl u_plate (
		.i_measuring (measuring),
		.i_pen_wait  (pen_wait),
		.i_meas      (cmd_reg.meas),
		.o_plate     (o_plate)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_result_out     = out_reg;
	assign o_result_out_oe  = ~i_chip_select_n; // [RULE_04]
	assign o_busy           = busy_reg;
	assign o_busy_oe        = ~i_chip_select_n; // [RULE_04]
	assign o_touch_irq_n    = 1'b0;
	assign o_touch_irq_n_oe = irq_drive_reg;
	assign o_sar_dac_code   = code_reg;
	assign o_sar_sample     = (state_reg == ST_ACQUIRE);
	assign o_result_word    = word_reg;
	assign o_result_valid   = valid_reg;
	assign o_power_down     = cmd_reg.power_down; // [RULE_18]
	assign o_pen_irq_en     = cmd_reg.pen_en;

endmodule

`default_nettype wire

// >>> tb/tsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Serial host
// ----
module tsc_host_model (
	input  wire logic i_clk,
	input  wire logic i_result_out,
	input  wire logic i_busy,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_cmd
);
	event        cmd_sent;
	logic [11:0] res;
	logic [2:0]  seen;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_cmd  = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Three cycles per phase, above the one-cycle sampling minimum
	task automatic frame(input logic [7:0] cmd, input int n, input logic csv);
		o_cs_n = csv;
		wait_n(3);
		for (int k = 1; k <= n; k++) begin
			o_cmd  = (k <= 8) ? cmd[8-k] : 1'b0;
			o_sclk = 1'b1;
			wait_n(3);
			if (k == 8) ->cmd_sent;
			o_sclk = 1'b0;
			wait_n(3);
			if (k == 8) seen[0] = i_busy;
			if (k == 9) seen[1] = i_busy;
			if (k >= 9 && k <= 20) res[20-k] = i_result_out;
			if (k == 21) seen[2] = i_result_out;
		end
		o_cmd  = 1'b0;
		o_cs_n = 1'b1;
		wait_n(3);
	endtask
endmodule
`default_nettype wire

// >>> tb/tsc_serial_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module tsc_serial_ctrl_checker (
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_chip_select_n,
	input wire logic        i_serial_clock,
	input wire logic        i_pen_touched,
	input wire logic        o_result_out,
	input wire logic        o_result_out_oe,
	input wire logic        o_busy,
	input wire logic        o_busy_oe,
	input wire logic        o_touch_irq_n,
	input wire logic        o_touch_irq_n_oe,
	input wire logic [11:0] o_sar_dac_code,
	input wire logic        o_result_valid,
	input wire logic        o_pen_irq_en
);
	logic       sclk_reg;
	logic [4:0] falls_reg;
	logic       fall;
	assign fall = sclk_reg & ~i_serial_clock & ~i_chip_select_n;
	always_ff @(posedge i_clk) begin
		sclk_reg <= i_serial_clock;
	end
	// Saturates so late stray edges cannot wrap back into the window
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_chip_select_n) begin
			falls_reg <= 5'h00;
		end else if (fall && falls_reg != 5'h1f) begin
			falls_reg <= falls_reg + 5'h01;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	oe_follows_cs_a: assert property (o_result_out_oe == !i_chip_select_n && o_busy_oe == !i_chip_select_n)
		else $error("output enables differ from chip select");
	busy_rise_a: assert property (fall && falls_reg == 5'h07 |=> o_busy)
		else $error("busy not high after eighth fall");
	busy_fall_a: assert property (fall && falls_reg == 5'h08 |=> !o_busy)
		else $error("busy not low after ninth fall");
	busy_window_a: assert property (o_busy |-> falls_reg == 5'h08)
		else $error("busy high outside its window");
	out_idle_low_a: assert property (!i_chip_select_n && (falls_reg <= 5'h08 || falls_reg >= 5'h15) |-> !o_result_out)
		else $error("result output not low while idle");
	out_on_fall_a: assert property (!i_chip_select_n && !fall |=> $stable(o_result_out))
		else $error("result output moved without a fall");
	valid_after_last_a: assert property (fall && falls_reg == 5'h13 |=> o_result_valid)
		else $error("result valid missing after last bit");
	valid_only_last_a: assert property (o_result_valid |-> $past(fall && falls_reg == 5'h13))
		else $error("result valid without a last bit");
	dac_msb_first_a: assert property (fall && falls_reg == 5'h07 |=> o_sar_dac_code == 12'h800)
		else $error("first trial code wrong");
	irq_follow_a: assert property (!$past(i_sys_rst) |-> !o_touch_irq_n &&
		o_touch_irq_n_oe == $past(i_chip_select_n && o_pen_irq_en && i_pen_touched))
		else $error("pen interrupt drive wrong");
	cover property (fall && falls_reg == 5'h08);
	cover property (o_result_valid);
	cover property (o_touch_irq_n_oe);
endmodule
bind tsc_serial_ctrl tsc_serial_ctrl_checker u_chk (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_select_n(i_chip_select_n),
	.i_serial_clock(i_serial_clock), .i_pen_touched(i_pen_touched), .o_result_out(o_result_out),
	.o_result_out_oe(o_result_out_oe), .o_busy(o_busy), .o_busy_oe(o_busy_oe),
	.o_touch_irq_n(o_touch_irq_n), .o_touch_irq_n_oe(o_touch_irq_n_oe),
	.o_sar_dac_code(o_sar_dac_code), .o_result_valid(o_result_valid), .o_pen_irq_en(o_pen_irq_en)
);
`default_nettype wire

// >>> tb/touch_adc_serial_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module touch_adc_serial_control_tb import tsc_pkg::*; ();
	logic           i_clk      = 1'b0;
	logic           i_sys_rst  = 1'b1;
	logic           pen        = 1'b0;
	logic           cmp        = 1'b0;
	logic [11:0]    vin        = 12'h000;
	int             failures   = 0;
	int             num_checks = 0;
	logic           cs_n, sclk, cmd, out, out_oe, busy, busy_oe, irq_n, irq_oe;
	logic           smp, valid, pd, pen_en, out_w, busy_w, irq_w;
	logic [11:0]    dac, word;
	tsc_plate_ctl_t plate;
	always #25 i_clk = ~i_clk;
	// Comparator lags the trial code by half a cycle, well inside a phase
	always @(negedge i_clk) cmp <= (vin >= dac);
	assign out_w  = out_oe ? out : 1'bz;
	assign busy_w = busy_oe ? busy : 1'bz;
	assign irq_w  = irq_oe ? irq_n : 1'b1;
	tsc_host_model host (.i_clk(i_clk), .i_result_out(out_w), .i_busy(busy_w),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_cmd(cmd));
	tsc_serial_ctrl uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_select_n(cs_n),
		.i_serial_clock(sclk), .i_cmd_in(cmd), .i_pen_touched(pen), .i_sar_cmp_high(cmp),
		.o_result_out(out), .o_result_out_oe(out_oe), .o_busy(busy), .o_busy_oe(busy_oe),
		.o_touch_irq_n(irq_n), .o_touch_irq_n_oe(irq_oe), .o_sar_dac_code(dac),
		.o_sar_sample(smp), .o_result_word(word), .o_result_valid(valid),
		.o_power_down(pd), .o_pen_irq_en(pen_en), .o_plate(plate));
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (failures == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	function automatic tsc_plate_ctl_t plate_exp(input logic [2:0] s);
		case (s)
			SRC_CODE_X:    return {5'h18, TSC_ADC_Y_PLUS};
			SRC_CODE_Y:    return {5'h06, TSC_ADC_X_PLUS};
			SRC_CODE_Z1:   return {5'h0c, TSC_ADC_X_PLUS};
			SRC_CODE_Z2:   return {5'h0c, TSC_ADC_Y_MINUS};
			SRC_CODE_BAT:  return {5'h00, TSC_ADC_BATTERY};
			SRC_CODE_AUXA: return {5'h00, TSC_ADC_AUX_A};
			SRC_CODE_AUXB: return {5'h00, TSC_ADC_AUX_B};
			default:       return {5'h00, TSC_ADC_TEMP};
		endcase
	endfunction
	task automatic t_reset();
		chk(12'(plate[7:3]), 12'h003);
		chk(12'({pd, pen_en}), 12'h003);
		chk(word, 12'h000);
		chk(12'(smp), 12'h000);
		chk(12'(irq_w), 12'h001);
	endtask
	// Every source code, every power-down code, codes 0 and full scale
	task automatic t_convert();
		logic [7:0]  c;
		logic [11:0] e;
		for (int i = 0; i < 8; i++) begin
			c   = {1'b1, 3'(i), 2'b00, 2'(i)};
			e   = (i == 7) ? 12'hfff : 12'(i * 12'h249);
			vin = e;
			fork
				host.frame(c, 24, 1'b0);
				begin
					@(host.cmd_sent);
					chk(12'(plate), 12'(plate_exp(3'(i))));
					chk(12'(smp), 12'h001);
				end
			join
			chk(host.res, e);
			chk(word, e);
			chk(12'(host.seen), 12'h001);
			chk(12'({pd, pen_en}), 12'({i % 4 == 0, i % 2 == 0}));
		end
	endtask
	// Partial frame, then a whole command with chip select high
	task automatic t_refuse();
		host.frame(8'h00, 4, 1'b0);
		chk(12'({pd, pen_en}), 12'h000);
		host.frame(8'h00, 8, 1'b1);
		chk(12'({pd, pen_en}), 12'h000);
	endtask
	task automatic t_irq();
		pen = 1'b1;
		repeat (3) @(negedge i_clk);
		chk(12'(irq_w), 12'h001);
		host.frame(8'h12, 8, 1'b0);
		chk(12'(irq_w), 12'h000);
		pen = 1'b0;
		repeat (3) @(negedge i_clk);
		chk(12'(irq_w), 12'h001);
	endtask
	initial begin
		repeat (10) @(negedge i_clk);
		i_sys_rst = 1'b0;
		@(negedge i_clk);
		t_reset();
		t_convert();
		t_refuse();
		t_irq();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
